// ### src/iack_map.svh
// Constants of the interrupt acknowledge and reset controller
`ifndef IACK_MAP_SVH
`define IACK_MAP_SVH

// Register offsets on the APB bus
`define IACK_OFS_CTRL 8'h00
`define IACK_OFS_MASK 8'h04
`define IACK_OFS_PEND 8'h08
`define IACK_OFS_STAT 8'h0c

// Field positions and widths
`define IACK_CTRL_MIE 0
`define IACK_MASK_W 4
`define IACK_NSRC 5
`define IACK_OPND_W 6
`define IACK_MASK_TC1 2
`define IACK_MASK_TC2_TMR 1
`define IACK_MASK_LOW 0

// Pending latch indices, lowest priority first
`define IACK_SRC_LOW 3'h0
`define IACK_SRC_TMR 3'h1
`define IACK_SRC_TC2 3'h2
`define IACK_SRC_TC1 3'h3
`define IACK_SRC_HIGH 3'h4
`define IACK_OPND_HIGH 5

// Entry addresses and the fetch start address
`define IACK_VEC_HIGH 12'h002
`define IACK_VEC_TC1 12'h006
`define IACK_VEC_TC2 12'h008
`define IACK_VEC_TMR 12'h00a
`define IACK_VEC_LOW 12'h00c
`define IACK_VEC_RESET 12'h000

// Reset pin least low time in clock cycles
`define IACK_RST_MIN_CYC 2'h3

// Master enable action of a latch-clear instruction
`define IACK_MIE_KEEP 2'h0
`define IACK_MIE_SET 2'h1
`define IACK_MIE_CLR 2'h2

`endif

// ### src/iack_pkg.sv
// Types of the interrupt acknowledge and reset controller
package iack_pkg;
    typedef enum logic [1:0] {ST_RUN, ST_PUSH, ST_VECTOR} iack_state_t;
    typedef struct packed {
        logic [2:0] shift;
    } iack_sync_st_t;
    typedef struct packed {
        logic pend;
    } iack_latch_st_t;
endpackage : iack_pkg

// ### src/iack_sync.sv
// Two-flop pin synchroniser with falling edge detection
`timescale 1ns/1ps
module iack_sync #(
    parameter logic IDLE_VAL = 1'b1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Pin and results
    input wire logic pin,
    output logic level,
    output logic fall
);
    import iack_pkg::*;

    iack_sync_st_t st_ff;
    iack_sync_st_t nxt_st;

    // Shift the pin in; only stages 1 and 2 are looked at
    always_comb begin
        nxt_st = st_ff;
        nxt_st.shift = {st_ff.shift[1:0], pin};
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_ff <= {3{IDLE_VAL}};
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Edge taken between synchronised stages, never the first one
    assign level = st_ff.shift[1];
    assign fall = st_ff.shift[2] & ~st_ff.shift[1];
endmodule : iack_sync

// ### src/iack_latch.sv
// One pending interrupt latch
`timescale 1ns/1ps
module iack_latch (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    input wire logic sync_clr,
    // Set and clear requests
    input wire logic set_pulse,
    input wire logic clr_pulse,
    // Latch state
    output logic pend
);
    import iack_pkg::*;

    iack_latch_st_t st_ff;
    iack_latch_st_t nxt_st;

    // A request in the clearing cycle survives: set beats clr_pulse, but sync_clr beats set
    always_comb begin
        nxt_st = st_ff;
        if (sync_clr) begin
            nxt_st.pend = 1'b0;
        end else if (set_pulse) begin
            nxt_st.pend = 1'b1;
        end else if (clr_pulse) begin
            nxt_st.pend = 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign pend = st_ff.pend;
endmodule : iack_latch

// ### src/iack_ctrl.sv
// Interrupt acceptance, acknowledge sequencing and reset pin handling
//
// The implementer's own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`include "iack_map.svh"

module iack_ctrl (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST,
    // APB slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Device pins
    input wire logic RESET_N_PIN,
    input wire logic EXT_IRQ_HIGH_PRIO,
    input wire logic EXT_IRQ_LOW_PRIO,
    // Internal interrupt sources, one-cycle pulses
    input wire logic COUNTER1_OVERFLOW_IRQ,
    input wire logic COUNTER2_OVERFLOW_IRQ,
    input wire logic INTERVAL_TICK_IRQ,
    // Instruction sequencer requests
    input wire logic INSTR_END,
    input wire logic COUNT_CYCLE,
    input wire logic RETURN_FROM_IRQ,
    input wire logic LATCH_CLR_STB,
    input wire logic [5:0] LATCH_CLR_OPERAND,
    input wire logic [1:0] LATCH_CLR_MIE_OP,
    // Instruction sequencer controls
    output logic SEQ_STALL,
    output logic STACK_PUSH,
    output logic STACK_POP,
    output logic PC_LOAD,
    output logic [11:0] PC_VECTOR,
    output logic SKIP_FLAG_SET,
    output logic FETCH_START,
    output logic CORE_RESET,
    output logic INTERVAL_TIMER_CLR
);
    import iack_pkg::*;

    typedef struct packed {
        iack_state_t state;
        logic [2:0] sel;
        logic mie;
        logic [3:0] mask;
        logic [1:0] rcnt;
        logic core_rst;
        logic fetch;
        logic push;
        logic pop;
        logic pcload;
        logic sfset;
        logic [11:0] vec;
        logic [31:0] prdata;
        logic pslverr;
    } iack_core_t;

    iack_core_t st_ff;
    iack_core_t nxt_st;

    logic rst_pin_lvl;
    logic high_lvl;
    logic high_fall;
    logic low_lvl;
    logic low_fall;
    logic [4:0] src_set;
    logic [4:0] src_clr;
    logic [4:0] pend;
    logic [4:0] enabled;
    logic [2:0] win;
    logic any_en;
    logic accept;
    logic instr_clr;
    logic apb_setup;
    logic apb_wr;
    logic [5:0] pend_il;

    // Pins come from outside the clock domain
    iack_sync #(.IDLE_VAL(1'b1)) u_sync_rst (
        .clk(CLK), .rst(RST), .pin(RESET_N_PIN), .level(rst_pin_lvl), .fall()
    );
    // falling edges of the interrupt pins
    iack_sync #(.IDLE_VAL(1'b1)) u_sync_high (
        .clk(CLK), .rst(RST), .pin(EXT_IRQ_HIGH_PRIO), .level(high_lvl), .fall(high_fall)
    );
    iack_sync #(.IDLE_VAL(1'b1)) u_sync_low (
        .clk(CLK), .rst(RST), .pin(EXT_IRQ_LOW_PRIO), .level(low_lvl), .fall(low_fall)
    );

    // Request sources in latch order
    always_comb begin
        src_set = '0;
        src_set[`IACK_SRC_LOW] = low_fall;
        src_set[`IACK_SRC_TMR] = INTERVAL_TICK_IRQ;
        src_set[`IACK_SRC_TC2] = COUNTER2_OVERFLOW_IRQ;
        src_set[`IACK_SRC_TC1] = COUNTER1_OVERFLOW_IRQ;
        src_set[`IACK_SRC_HIGH] = high_fall;
    end

    assign instr_clr = LATCH_CLR_STB & ~st_ff.core_rst;

    // latches, one per source; clears from acceptance or instruction
    genvar gi;
    generate
        for (gi = 0; gi < `IACK_NSRC; gi++) begin : g_latch
            localparam int OPB = (gi == `IACK_SRC_HIGH) ? `IACK_OPND_HIGH : gi;
            // only the selected latch clears at acknowledge
            // operand zero clears, one holds; no set path
            assign src_clr[gi] = ((st_ff.state == ST_VECTOR) && (st_ff.sel == 3'(gi)))
                | (instr_clr & ~LATCH_CLR_OPERAND[OPB]);
            iack_latch u_latch (
                .clk(CLK),
                .rst(RST),
                .sync_clr(st_ff.core_rst),
                .set_pulse(src_set[gi]),
                .clr_pulse(src_clr[gi]),
                .pend(pend[gi])
            );
        end
    endgenerate

    // mask mapping; high input bypasses the mask; low gated
    always_comb begin
        enabled = '0;
        enabled[`IACK_SRC_LOW] = pend[`IACK_SRC_LOW] & st_ff.mask[`IACK_MASK_LOW];
        enabled[`IACK_SRC_TMR] = pend[`IACK_SRC_TMR] & st_ff.mask[`IACK_MASK_TC2_TMR];
        enabled[`IACK_SRC_TC2] = pend[`IACK_SRC_TC2] & st_ff.mask[`IACK_MASK_TC2_TMR];
        enabled[`IACK_SRC_TC1] = pend[`IACK_SRC_TC1] & st_ff.mask[`IACK_MASK_TC1];
        enabled[`IACK_SRC_HIGH] = pend[`IACK_SRC_HIGH];
    end

    // priority pick: later (higher) index overrides earlier
    always_comb begin
        win = `IACK_SRC_LOW;
        any_en = 1'b0;
        for (int i = 0; i < `IACK_NSRC; i++) begin
            if (enabled[i]) begin
                win = 3'(i);
                any_en = 1'b1;
            end
        end
    end

    // boundary only, after any counter cycle; nesting via mie
    assign accept = (st_ff.state == ST_RUN) && INSTR_END && !COUNT_CYCLE
        && st_ff.mie && any_en && !st_ff.core_rst;

    // Pending view in the instruction operand layout
    assign pend_il = {pend[`IACK_SRC_HIGH], 1'b0, pend[`IACK_SRC_TC1:`IACK_SRC_LOW]};

    assign apb_setup = PSEL && !PENABLE;
    assign apb_wr = PSEL && PENABLE && PWRITE;

    // Next state of the whole controller
    always_comb begin
        nxt_st = st_ff;
        nxt_st.push = 1'b0;
        nxt_st.pop = 1'b0;
        nxt_st.pcload = 1'b0;
        nxt_st.fetch = 1'b0;
        nxt_st.sfset = st_ff.core_rst;

        // count low reset pin cycles, saturating
        if (rst_pin_lvl) begin
            nxt_st.rcnt = '0;
        end else if (st_ff.rcnt != `IACK_RST_MIN_CYC) begin
            nxt_st.rcnt = st_ff.rcnt + 2'h1;
        end

        // Sequencer: acknowledge in two cycles, no instruction runs
        unique case (st_ff.state)
            ST_RUN: begin
                if (accept) begin
                    nxt_st.state = ST_PUSH;
                    nxt_st.sel = win;
                    nxt_st.push = 1'b1;
                end else if (RETURN_FROM_IRQ && !st_ff.core_rst) begin
                    // pop PC and flags, enable again
                    nxt_st.pop = 1'b1;
                    nxt_st.mie = 1'b1;
                end
            end
            ST_PUSH: begin
                // entry address to PC; status flag forced
                nxt_st.state = ST_VECTOR;
                nxt_st.pcload = 1'b1;
                nxt_st.sfset = 1'b1;
                unique case (st_ff.sel)
                    `IACK_SRC_HIGH: nxt_st.vec = `IACK_VEC_HIGH;
                    `IACK_SRC_TC1: nxt_st.vec = `IACK_VEC_TC1;
                    `IACK_SRC_TC2: nxt_st.vec = `IACK_VEC_TC2;
                    `IACK_SRC_TMR: nxt_st.vec = `IACK_VEC_TMR;
                    default: nxt_st.vec = `IACK_VEC_LOW;
                endcase
                nxt_st.mie = 1'b0;
            end
            ST_VECTOR: begin
                // Entry instruction fetched from here on
                nxt_st.state = ST_RUN;
            end
        endcase

        // Latch-clear instruction also steers the master enable
        if (instr_clr && st_ff.state == ST_RUN && !accept) begin
            if (LATCH_CLR_MIE_OP == `IACK_MIE_SET) begin
                nxt_st.mie = 1'b1;
            end else if (LATCH_CLR_MIE_OP == `IACK_MIE_CLR) begin
                nxt_st.mie = 1'b0;
            end
        end

        // APB writes: enable and source mask
        if (apb_wr && st_ff.state == ST_RUN && !accept) begin
            if (PADDR == `IACK_OFS_CTRL) begin
                nxt_st.mie = PWDATA[`IACK_CTRL_MIE];
            end
        end
        if (apb_wr && PADDR == `IACK_OFS_MASK) begin
            nxt_st.mask = PWDATA[`IACK_MASK_W-1:0];
        end

        // APB read data captured in the setup cycle
        if (apb_setup) begin
            nxt_st.prdata = '0;
            nxt_st.pslverr = 1'b0;
            unique case (PADDR)
                `IACK_OFS_CTRL: nxt_st.prdata[`IACK_CTRL_MIE] = st_ff.mie;
                `IACK_OFS_MASK: nxt_st.prdata[`IACK_MASK_W-1:0] = st_ff.mask;
                `IACK_OFS_PEND: nxt_st.prdata[`IACK_OPND_W-1:0] = pend_il;
                `IACK_OFS_STAT: nxt_st.prdata[17:0] = {low_lvl, high_lvl, st_ff.vec,
                    st_ff.sel, st_ff.state != ST_RUN};
                default: nxt_st.pslverr = 1'b1;
            endcase
        end

        // core reset wins over everything; release fetches at zero
        if (st_ff.core_rst) begin
            nxt_st.state = ST_RUN;
            nxt_st.mie = 1'b0;
            nxt_st.mask = '0;
            nxt_st.vec = `IACK_VEC_RESET;
            if (rst_pin_lvl) begin
                nxt_st.core_rst = 1'b0;
                nxt_st.fetch = 1'b1;
                nxt_st.pcload = 1'b1;
            end
        end else if (nxt_st.rcnt == `IACK_RST_MIN_CYC) begin
            nxt_st.core_rst = 1'b1;
            nxt_st.state = ST_RUN;
        end
    end

    // Only constants under the asynchronous reset
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            st_ff <= '{state: ST_RUN, sel: `IACK_SRC_LOW, mie: 1'b0, mask: '0, rcnt: '0,
                core_rst: 1'b1, fetch: 1'b0, push: 1'b0, pop: 1'b0, pcload: 1'b0,
                sfset: 1'b1, vec: `IACK_VEC_RESET, prdata: '0, pslverr: 1'b0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Outputs; nothing beyond PC and flags is ever saved here
    assign PRDATA = st_ff.prdata;
    assign PREADY = 1'b1;
    assign PSLVERR = st_ff.pslverr & PSEL & PENABLE;
    // sequencer holds while acknowledging or in reset
    assign SEQ_STALL = (st_ff.state != ST_RUN) | st_ff.core_rst;
    assign STACK_PUSH = st_ff.push;
    assign STACK_POP = st_ff.pop;
    assign PC_LOAD = st_ff.pcload;
    assign PC_VECTOR = st_ff.vec;
    assign SKIP_FLAG_SET = st_ff.sfset;
    assign FETCH_START = st_ff.fetch;
    assign CORE_RESET = st_ff.core_rst;
    assign INTERVAL_TIMER_CLR = st_ff.core_rst;

    // Checks kept beside the logic
    a_ack_two_cycles: assert property (@(posedge CLK) disable iff (RST)
        accept |=> STACK_PUSH ##1 (PC_LOAD && !FETCH_START) ##1 !SEQ_STALL)
        else $error("acknowledge did not finish in two cycles");
    a_push_first: assert property (@(posedge CLK) disable iff (RST)
        $rose(STACK_PUSH) |-> !PC_LOAD ##1 PC_LOAD)
        else $error("push did not precede vector load");
    a_vector_value: assert property (@(posedge CLK) disable iff (RST)
        (accept && win == `IACK_SRC_HIGH) |-> ##2 PC_VECTOR == `IACK_VEC_HIGH)
        else $error("wrong entry address for high input");
    a_sf_forced: assert property (@(posedge CLK) disable iff (RST)
        (PC_LOAD && !FETCH_START) |-> SKIP_FLAG_SET)
        else $error("status flag not set at vector load");
    a_mie_cleared: assert property (@(posedge CLK) disable iff (RST)
        accept |-> ##2 !st_ff.mie)
        else $error("master enable still set after acknowledge");
    a_only_selected: assert property (@(posedge CLK) disable iff (RST)
        (st_ff.state == ST_VECTOR && !LATCH_CLR_STB && !st_ff.core_rst && src_set == '0)
        |=> pend == ($past(pend) & ~(5'h01 << $past(st_ff.sel))))
        else $error("acknowledge touched another latch");
    a_return_from_irq_restore: assert property (@(posedge CLK) disable iff (RST)
        (RETURN_FROM_IRQ && !accept && st_ff.state == ST_RUN && !st_ff.core_rst)
        |=> STACK_POP && st_ff.mie)
        else $error("return did not pop and enable");
    a_pin_latches: assert property (@(posedge CLK) disable iff (RST)
        (high_fall && !st_ff.core_rst) |=> pend[`IACK_SRC_HIGH])
        else $error("falling edge not latched");
    a_high_unmasked: assert property (@(posedge CLK) disable iff (RST)
        (st_ff.state == ST_RUN && INSTR_END && !COUNT_CYCLE && st_ff.mie
        && pend[`IACK_SRC_HIGH] && !st_ff.core_rst)
        |=> st_ff.state == ST_PUSH && st_ff.sel == `IACK_SRC_HIGH)
        else $error("high input not taken first");
    a_low_gated: assert property (@(posedge CLK) disable iff (RST)
        (accept && win == `IACK_SRC_LOW) |-> st_ff.mask[`IACK_MASK_LOW])
        else $error("low input taken while masked");
    a_reset_fetch: assert property (@(posedge CLK) disable iff (RST)
        $fell(st_ff.core_rst) |-> FETCH_START && PC_VECTOR == `IACK_VEC_RESET)
        else $error("reset release did not fetch at zero");
    a_reset_clears: assert property (@(posedge CLK) disable iff (RST)
        st_ff.core_rst |=> !st_ff.mie && st_ff.mask == '0 && pend == '0)
        else $error("core reset left state behind");
    a_no_instr_set: assert property (@(posedge CLK) disable iff (RST)
        (src_set == '0) |=> (pend & ~$past(pend)) == '0)
        else $error("latch set without a request");
    a_boundary_only: assert property (@(posedge CLK) disable iff (RST)
        $rose(STACK_PUSH) |-> $past(INSTR_END) && !$past(COUNT_CYCLE))
        else $error("acceptance off an instruction boundary");
endmodule : iack_ctrl

// ### tb/iack_seq_model.sv
// Model of the instruction sequencer and of the external pins
`timescale 1ns/1ps
module iack_seq_model (
    // Clock
    input wire logic clk,
    // Block status
    input wire logic seq_stall,
    input wire logic core_reset,
    // Sequencer and pins
    output logic instr_end,
    output logic count_cycle,
    output logic ext_high,
    output logic ext_low,
    output logic reset_n_pin
);
    logic phase;

    // Pins idle high, no counter cycles inserted
    initial begin
        instr_end = 1'b0;
        count_cycle = 1'b0;
        ext_high = 1'b1;
        ext_low = 1'b1;
        reset_n_pin = 1'b1;
        phase = 1'b0;
    end

    // Two-cycle instructions; no boundary while the block stalls the core
    always @(posedge clk) begin
        phase <= ~phase;
        instr_end <= phase & ~seq_stall & ~core_reset;
    end

    task automatic pin_fall(input logic hi);
        @(posedge clk);
        if (hi) ext_high <= 1'b0; else ext_low <= 1'b0;
        repeat (4) @(posedge clk);
        if (hi) ext_high <= 1'b1; else ext_low <= 1'b1;
        repeat (4) @(posedge clk);
    endtask : pin_fall

    // reset pin low for the given count
    task automatic rst_low(input int n);
        @(posedge clk);
        reset_n_pin <= 1'b0;
        repeat (n) @(posedge clk);
        reset_n_pin <= 1'b1;
    endtask : rst_low
endmodule : iack_seq_model

// ### tb/iack_ctrl_tb_top.sv
// Self-checking bench of the acknowledge and reset controller
`timescale 1ns/1ps
`include "iack_map.svh"
module iack_ctrl_tb_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr;
    logic [2:0] src = 3'h0;
    logic ret = 1'b0;
    logic lc_stb = 1'b0;
    logic [5:0] lc_opnd = 6'h3f;
    logic [1:0] lc_op = 2'h0;
    logic instr_end, count_cycle, ext_high, ext_low, reset_n;
    logic seq_stall, stack_push, stack_pop, pc_load, skip_set, fetch_start, core_reset, timer_clr;
    logic [11:0] pc_vector;
    logic [31:0] q;
    logic e;
    int error_cnt = 0;
    int n_checks = 0;

    // 125 MHz clock
    always #4 clk = ~clk;

    iack_seq_model seq (.clk(clk), .seq_stall(seq_stall), .core_reset(core_reset),
        .instr_end(instr_end), .count_cycle(count_cycle), .ext_high(ext_high),
        .ext_low(ext_low), .reset_n_pin(reset_n));

    iack_ctrl dut (.CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .RESET_N_PIN(reset_n), .EXT_IRQ_HIGH_PRIO(ext_high), .EXT_IRQ_LOW_PRIO(ext_low),
        .COUNTER1_OVERFLOW_IRQ(src[0]), .COUNTER2_OVERFLOW_IRQ(src[1]),
        .INTERVAL_TICK_IRQ(src[2]), .INSTR_END(instr_end), .COUNT_CYCLE(count_cycle),
        .RETURN_FROM_IRQ(ret), .LATCH_CLR_STB(lc_stb), .LATCH_CLR_OPERAND(lc_opnd),
        .LATCH_CLR_MIE_OP(lc_op), .SEQ_STALL(seq_stall), .STACK_PUSH(stack_push),
        .STACK_POP(stack_pop), .PC_LOAD(pc_load), .PC_VECTOR(pc_vector),
        .SKIP_FLAG_SET(skip_set), .FETCH_START(fetch_start), .CORE_RESET(core_reset),
        .INTERVAL_TIMER_CLR(timer_clr));

    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : close_out

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    // One APB transfer; waits for pready, takes the answer at that edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && k < 16) begin
            @(posedge clk);
            k++;
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(nm, exp, q);
    endtask : rd

    task automatic pulse(input int i);
        @(posedge clk);
        src[i] <= 1'b1;
        @(posedge clk);
        src[i] <= 1'b0;
    endtask : pulse

    task automatic lclr(input logic [5:0] r, input logic [1:0] op);
        @(posedge clk);
        lc_stb <= 1'b1;
        lc_opnd <= r;
        lc_op <= op;
        @(posedge clk);
        lc_stb <= 1'b0;
    endtask : lclr

    // Bounded wait for the fetch pulse or for core reset
    task automatic wait_on(input logic fetch);
        int k;
        k = 0;
        while ((fetch ? fetch_start : core_reset) !== 1'b1 && k < 40) begin
            @(posedge clk);
            #1;
            k++;
        end
    endtask : wait_on

    // Follows one acknowledge: push first, vector load one cycle later
    task automatic wait_ack(input logic [11:0] vec);
        int k;
        k = 0;
        @(posedge clk);
        #1;
        while (stack_push !== 1'b1 && k < 30) begin
            @(posedge clk);
            #1;
            k++;
        end
        chk("push", 32'h1, 32'(stack_push));
        @(posedge clk);
        #1;
        chk("pc_load", 32'h1, 32'(pc_load));
        chk("vector", 32'(vec), 32'(pc_vector));
        chk("skip_set", 32'h1, 32'(skip_set));
        chk("stall", 32'h1, 32'(seq_stall));
    endtask : wait_ack

    // Hang guard, well beyond the few hundred cycles the tests need
    initial begin
        #100000;
        error_cnt++;
        close_out();
    end

    initial begin
        repeat (10) @(posedge clk);
        chk("timer_clr", 32'h1, 32'(timer_clr));
        chk("skip_rst", 32'h1, 32'(skip_set));
        rst <= 1'b0;
        wait_on(1'b1);
        chk("fetch", 32'h1, 32'(fetch_start));
        chk("fetch_pc", 32'h0, 32'(pc_vector));
        rd("ctrl", `IACK_OFS_CTRL, 32'h0);
        rd("mask", `IACK_OFS_MASK, 32'h0);
        rd("pend", `IACK_OFS_PEND, 32'h0);
        // Unmapped offset answers with an error and reads zero
        rd("unmapped", 8'h10, 32'h0);
        chk("slverr", 32'h1, 32'(e));
        $display("test reset done");
        // Enabled but masked requests stay latched
        apb(1'b1, `IACK_OFS_CTRL, 32'h1);
        pulse(0);
        seq.pin_fall(1'b0);
        rd("pend_masked", `IACK_OFS_PEND, 32'h09);
        $display("test masked done");
        fork
            seq.pin_fall(1'b1);
            wait_ack(`IACK_VEC_HIGH);
        join
        rd("pend_high", `IACK_OFS_PEND, 32'h09);
        rd("ctrl_ack", `IACK_OFS_CTRL, 32'h0);
        @(posedge clk);
        ret <= 1'b1;
        @(posedge clk);
        ret <= 1'b0;
        #1;
        chk("pop", 32'h1, 32'(stack_pop));
        rd("ctrl_ret", `IACK_OFS_CTRL, 32'h1);
        rd("pend_ret", `IACK_OFS_PEND, 32'h09);
        $display("test high done");
        // Counter 1 outranks the low external input once both are enabled
        apb(1'b1, `IACK_OFS_MASK, 32'h7);
        wait_ack(`IACK_VEC_TC1);
        rd("pend_tc1", `IACK_OFS_PEND, 32'h01);
        lclr(6'h3f, `IACK_MIE_SET);
        wait_ack(`IACK_VEC_LOW);
        rd("pend_low", `IACK_OFS_PEND, 32'h0);
        $display("test priority done");
        // Clear instructions clear zero bits only and never set a latch
        pulse(1);
        pulse(2);
        rd("pend_two", `IACK_OFS_PEND, 32'h06);
        lclr(6'h39, `IACK_MIE_KEEP);
        rd("pend_clr", `IACK_OFS_PEND, 32'h0);
        lclr(6'h3f, `IACK_MIE_KEEP);
        rd("pend_hold", `IACK_OFS_PEND, 32'h0);
        $display("test clear done");
        // A short low pulse on the reset pin is ignored, a long one resets
        seq.rst_low(2);
        repeat (8) @(posedge clk);
        chk("short_rst", 32'h0, 32'(core_reset));
        seq.rst_low(6);
        wait_on(1'b0);
        chk("core_rst", 32'h1, 32'(core_reset));
        chk("timer_pin", 32'h1, 32'(timer_clr));
        wait_on(1'b1);
        chk("pin_fetch", 32'h1, 32'(fetch_start));
        chk("pin_pc", 32'h0, 32'(pc_vector));
        rd("mask_pin", `IACK_OFS_MASK, 32'h0);
        rd("ctrl_pin", `IACK_OFS_CTRL, 32'h0);
        $display("test pin reset done");
        close_out();
    end
endmodule : iack_ctrl_tb_top
